// *** logic/sbseq_map.svh ***
// sbseq_map.svh - timing counts and constant codes for the standby boot pair
// assumes: included by bare name from the package and the design modules
`ifndef SBSEQ_MAP_SVH
`define SBSEQ_MAP_SVH

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define SBSEQ_CLK_PERIOD_NS 10
`define SBSEQ_SYNC_STAGES   2
`define SBSEQ_HOLD_NS       1000
`define SBSEQ_HOLD_CYC      ((`SBSEQ_HOLD_NS + `SBSEQ_CLK_PERIOD_NS - 1) / `SBSEQ_CLK_PERIOD_NS)

// ------------------------------------------------------------------
// identity check result codes
// ------------------------------------------------------------------
`define SBSEQ_ID_PENDING    2'h0
`define SBSEQ_ID_PASS       2'h1
`define SBSEQ_ID_FAIL       2'h2
`define SBSEQ_ID_ABSENT     2'h3

`endif

// *** logic/sbseq_pkg.sv ***
// sbseq_pkg.sv - types shared by both ends of the standby boot link
// assumes: compiled before the interface and the modules
`include "sbseq_map.svh"

package sbseq_pkg;

    // module end sequencer states, one-hot
    typedef enum logic [7:0]
    {
        SBSEQ_M_IDLE  = 8'b0000_0001,
        SBSEQ_M_BOOT  = 8'b0000_0010,
        SBSEQ_M_CHECK = 8'b0000_0100,
        SBSEQ_M_STBY  = 8'b0000_1000,
        SBSEQ_M_RSTR  = 8'b0001_0000,
        SBSEQ_M_SOFT  = 8'b0010_0000,
        SBSEQ_M_ON    = 8'b0100_0000,
        SBSEQ_M_HALT  = 8'b1000_0000
    } sbseq_mst_e;

    // host end sequencer states, one-hot
    typedef enum logic [5:0]
    {
        SBSEQ_H_OFF   = 6'b00_0001,
        SBSEQ_H_AUX   = 6'b00_0010,
        SBSEQ_H_RDY   = 6'b00_0100,
        SBSEQ_H_S5    = 6'b00_1000,
        SBSEQ_H_ON    = 6'b01_0000,
        SBSEQ_H_WAIT  = 6'b10_0000
    } sbseq_hst_e;

    typedef logic [1:0] sbseq_id_t;

endpackage

// *** logic/sbseq_if.sv ***
// sbseq_if.sv - connector signals between control module and host board
// assumes: presence loop a driven by the module from synchronised loop b
`timescale 1ns/1ns
`default_nettype none

interface sbseq_if;
    logic presence_loop_a;              // host pulls up; low = module present
    logic presence_loop_b_grounded;     // host grounds second loop line
    logic module_standby_enable_out;    // module -> host, active high
    logic host_standby_ready_in;        // host -> module, active high
    logic module_standby_reset_out_low; // module -> host, active low
    logic soft_off_grant;               // module -> host, virtual grant bit
    logic power_on_grant;               // module -> host
    logic cover_open_input_low;         // host -> module, low = intruded
    logic uart0_m2h;                    // console, no flow control
    logic uart0_h2m;
    logic uart1_m2h;
    logic uart1_h2m;

    modport control_module
    (
        input  presence_loop_b_grounded,
        output presence_loop_a,
        output module_standby_enable_out,
        input  host_standby_ready_in,
        output module_standby_reset_out_low,
        output soft_off_grant,
        output power_on_grant,
        input  cover_open_input_low,
        output uart0_m2h,
        input  uart0_h2m,
        output uart1_m2h,
        input  uart1_h2m
    );

    modport host_processor_board
    (
        input  presence_loop_a,
        output presence_loop_b_grounded,
        input  module_standby_enable_out,
        output host_standby_ready_in,
        input  module_standby_reset_out_low,
        input  soft_off_grant,
        input  power_on_grant,
        output cover_open_input_low,
        input  uart0_m2h,
        output uart0_h2m,
        input  uart1_m2h,
        output uart1_h2m
    );
endinterface

`default_nettype wire

// *** logic/sbseq_sync.sv ***
// sbseq_sync.sv - multi-stage level synchroniser
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module sbseq_sync
#(
    parameter int   STAGES = 2,
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic i_clk_sys, // system clock
    input  wire logic i_reset_n, // sync reset, active low
    input  wire logic i_async,   // raw level
    output logic      o_sync     // synchronised level
);
    logic [STAGES-1:0] chain_q;

    // shift chain; only the last stage is read outside
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            chain_q <= {STAGES{RST_VAL}};
        else
            chain_q <= {chain_q[STAGES-2:0], i_async};
    end

    assign o_sync = chain_q[STAGES-1];
endmodule

`default_nettype wire

// *** logic/sbseq_module_end.sv ***
// sbseq_module_end.sv - control module side of the standby boot handshake
// assumes: firmware reports identity check result and rail status as levels
`timescale 1ns/1ns
`default_nettype none

`include "sbseq_map.svh"

// Contract
// - host enables module power from loop low
// - host keeps aux off without presence
// - controller boots then reads host identity
// - standby enable only after pass and rails
// - incompatible or absent identity halts forever
// - host raises ready once rails regulate; here ready also waits for fpga config done
// - hold standby reset until ready seen
// - soft-off interfaces wait for reset release
// - grant soft-off entry after reset release
// - host blocks power-on until grant
// - host sequences to on after grant
// - intrusion input active low
// - both uarts without flow control
// - discovery steps never skipped
module sbseq_module_end
    import sbseq_pkg::*;
#(
    parameter int SYNC_STAGES = `SBSEQ_SYNC_STAGES
)
(
    input  wire logic    i_clk_sys,        // system clock
    input  wire logic    i_reset_n,        // sync reset, active low
    sbseq_if.control_module link,          // connector side
    input  wire logic    i_aux_rails_good, // own aux regulators up
    input  wire logic    i_ctrl_booted,    // controller ready to read id
    input  wire logic    i_stby_rails_good,// own standby rails good
    input  wire sbseq_id_t i_id_result,    // identity check outcome
    input  wire logic    i_power_on_req,   // firmware power-on grant
    input  wire logic    i_uart0_tx,       // console tx
    input  wire logic    i_uart1_tx,       // subsystem tx
    output logic         o_uart0_rx,       // console rx
    output logic         o_uart1_rx,       // subsystem rx
    output logic         o_id_read_req,    // ask firmware to read id
    output logic         o_intruded,       // cover removed
    output logic         o_halted,         // boot stopped
    output sbseq_mst_e   o_state           // current step
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        sbseq_mst_e st;
        logic       stby_en;
        logic       rst_rel;
        logic       s5_grant;
        logic       on_grant;
        logic       intruded;
        logic       rx0;
        logic       rx1;
    } sbseq_mstate_s;

    sbseq_mstate_s s_q;
    sbseq_mstate_s s_d;
    logic          rdy_s;
    logic          cover_s;
    logic          loop_s;

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    // two-stage input sync
    sbseq_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_rdy
    (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_async   (link.host_standby_ready_in),
        .o_sync    (rdy_s)
    );
    // reset value high so a held line reads as not intruded
    sbseq_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b1)) u_cov
    (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_async   (link.cover_open_input_low),
        .o_sync    (cover_s)
    );
    sbseq_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b1)) u_loop
    (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_async   (link.presence_loop_b_grounded),
        .o_sync    (loop_s)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.intruded = ~cover_s;
        s_d.rx0 = link.uart0_h2m;
        s_d.rx1 = link.uart1_h2m;
        // each step needs the one before
        unique case (s_q.st)
            SBSEQ_M_IDLE:
            begin
                if (i_aux_rails_good)
                    s_d.st = SBSEQ_M_BOOT;
            end
            SBSEQ_M_BOOT:
            begin
                if (i_ctrl_booted)
                    s_d.st = SBSEQ_M_CHECK;
            end
            SBSEQ_M_CHECK:
            begin
                // halt on bad or missing id
                if (i_id_result == `SBSEQ_ID_FAIL ||
                    i_id_result == `SBSEQ_ID_ABSENT)
                    s_d.st = SBSEQ_M_HALT;
                else if (i_id_result == `SBSEQ_ID_PASS && i_stby_rails_good)
                begin
                    s_d.st      = SBSEQ_M_STBY;
                    s_d.stby_en = 1'b1;
                end
            end
            SBSEQ_M_STBY:
            begin
                if (rdy_s)
                begin
                    s_d.st      = SBSEQ_M_RSTR;
                    s_d.rst_rel = 1'b1;
                end
            end
            SBSEQ_M_RSTR:
            begin
                s_d.st       = SBSEQ_M_SOFT;
                s_d.s5_grant = 1'b1;
            end
            SBSEQ_M_SOFT:
            begin
                if (i_power_on_req)
                begin
                    s_d.st       = SBSEQ_M_ON;
                    s_d.on_grant = 1'b1;
                end
            end
            SBSEQ_M_ON:
            begin
                s_d.st = SBSEQ_M_ON;
            end
            SBSEQ_M_HALT:
            begin
                s_d.st = SBSEQ_M_HALT;
            end
            default:
            begin
                s_d.st = SBSEQ_M_HALT;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            s_q          <= '0;
            s_q.st       <= SBSEQ_M_IDLE;
            s_q.intruded <= 1'b0;
            s_q.rx0      <= 1'b1;
            s_q.rx1      <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // loopback drives loop a from grounded b
    assign link.presence_loop_a              = loop_s;
    assign link.module_standby_enable_out    = s_q.stby_en;
    assign link.module_standby_reset_out_low = s_q.rst_rel;
    // soft-off use gated by reset release
    assign link.soft_off_grant = s_q.s5_grant & s_q.rst_rel;
    assign link.power_on_grant = s_q.on_grant;
    assign link.uart0_m2h      = i_uart0_tx;
    assign link.uart1_m2h      = i_uart1_tx;
    assign o_uart0_rx          = s_q.rx0;
    assign o_uart1_rx          = s_q.rx1;
    assign o_id_read_req       = (s_q.st == SBSEQ_M_CHECK);
    assign o_intruded          = s_q.intruded;
    assign o_halted            = (s_q.st == SBSEQ_M_HALT);
    assign o_state             = s_q.st;
endmodule

`default_nettype wire

// *** logic/sbseq_host_end.sv ***
// sbseq_host_end.sv - host board sequencing logic side
// assumes: board reports its aux rails and fpga status as levels
`timescale 1ns/1ns
`default_nettype none

`include "sbseq_map.svh"

module sbseq_host_end
    import sbseq_pkg::*;
#(
    parameter int SYNC_STAGES = `SBSEQ_SYNC_STAGES
)
(
    input  wire logic i_clk_sys,         // system clock
    input  wire logic i_reset_n,         // sync reset, active low
    sbseq_if.host_processor_board link,  // connector side
    input  wire logic i_aux_rails_good,  // own aux rails regulate
    input  wire logic i_fpga_configured, // config done, needed before ready
    input  wire logic i_wake_req,        // any wake source
    input  wire logic i_cover_closed,    // intrusion switch state
    input  wire logic i_uart0_tx,        // console tx
    input  wire logic i_uart1_tx,        // subsystem tx
    output logic      o_uart0_rx,        // console rx
    output logic      o_uart1_rx,        // subsystem rx
    output logic      o_module_power_en, // enable power to module
    output logic      o_aux_enable,      // standby power enable
    output logic      o_standby_reset_low, // to standby devices
    output logic      o_chipset_s5_en,   // let chipset enter soft-off
    output logic      o_host_on,         // sequence host fully on
    output sbseq_hst_e o_state           // current step
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed
    {
        sbseq_hst_e st;
        logic       rdy;
        logic       on;
        logic       rx0;
        logic       rx1;
    } sbseq_hstate_s;

    sbseq_hstate_s s_q;
    sbseq_hstate_s s_d;
    logic          loop_s;
    logic          en_s;
    logic          rst_s;
    logic          s5g_s;
    logic          ong_s;
    logic          present;

    // ------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------
    // sync incoming levels
    sbseq_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b1)) u_loop
    (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
     .i_async(link.presence_loop_a), .o_sync(loop_s));
    sbseq_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_en
    (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
     .i_async(link.module_standby_enable_out), .o_sync(en_s));
    sbseq_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_rst
    (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
     .i_async(link.module_standby_reset_out_low), .o_sync(rst_s));
    sbseq_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_s5g
    (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
     .i_async(link.soft_off_grant), .o_sync(s5g_s));
    sbseq_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_ong
    (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
     .i_async(link.power_on_grant), .o_sync(ong_s));

    assign present = ~loop_s;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_d     = s_q;
        s_d.rx0 = link.uart0_m2h;
        s_d.rx1 = link.uart1_m2h;
        unique case (s_q.st)
            SBSEQ_H_OFF:
            begin
                if (present)
                    s_d.st = SBSEQ_H_WAIT;
            end
            SBSEQ_H_WAIT:
            begin
                if (en_s)
                    s_d.st = SBSEQ_H_AUX;
            end
            SBSEQ_H_AUX:
            begin
                if (i_aux_rails_good && i_fpga_configured)
                begin
                    s_d.st  = SBSEQ_H_RDY;
                    s_d.rdy = 1'b1;
                end
            end
            SBSEQ_H_RDY:
            begin
                if (rst_s && s5g_s)
                    s_d.st = SBSEQ_H_S5;
            end
            SBSEQ_H_S5:
            begin
                if (ong_s && i_wake_req)
                begin
                    s_d.st = SBSEQ_H_ON;
                    s_d.on = 1'b1;
                end
            end
            SBSEQ_H_ON:
            begin
                s_d.st = SBSEQ_H_ON;
            end
            default:
            begin
                s_d.st = SBSEQ_H_OFF;
            end
        endcase
        if (!present)
        begin
            s_d.st  = SBSEQ_H_OFF;
            s_d.rdy = 1'b0;
            s_d.on  = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            s_q     <= '0;
            s_q.st  <= SBSEQ_H_OFF;
            s_q.rx0 <= 1'b1;
            s_q.rx1 <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.presence_loop_b_grounded = 1'b0;
    assign link.host_standby_ready_in    = s_q.rdy;
    assign link.cover_open_input_low     = i_cover_closed;
    assign link.uart0_h2m    = i_uart0_tx;
    assign link.uart1_h2m    = i_uart1_tx;
    assign o_uart0_rx        = s_q.rx0;
    assign o_uart1_rx        = s_q.rx1;
    assign o_module_power_en = present;
    assign o_aux_enable      = present & en_s;
    assign o_standby_reset_low = rst_s;
    assign o_chipset_s5_en   = (s_q.st == SBSEQ_H_S5) | (s_q.st == SBSEQ_H_ON);
    assign o_host_on         = s_q.on;
    assign o_state           = s_q.st;
endmodule

`default_nettype wire

// *** tb/sbseq_monitor.sv ***
// sbseq_monitor.sv - handshake checks on the standby boot connector
// assumes: fed from the interface signals, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none

module sbseq_monitor
(
    input wire logic i_clk_sys,                      // system clock
    input wire logic i_reset_n,                      // sync reset, low
    input wire logic i_module_standby_enable_out,    // standby enable
    input wire logic i_host_standby_ready_in,        // host ready
    input wire logic i_module_standby_reset_out_low, // standby reset
    input wire logic i_soft_off_grant,               // soft-off grant
    input wire logic i_power_on_grant                // power-on grant
);
    wire logic en;
    wire logic rdy;
    wire logic rst;
    wire logic soft_off_grant;
    wire logic power_on_grant;

    // short aliases keep properties on one line
    assign en             = i_module_standby_enable_out;
    assign rdy            = i_host_standby_ready_in;
    assign rst            = i_module_standby_reset_out_low;
    assign soft_off_grant = i_soft_off_grant;
    assign power_on_grant = i_power_on_grant;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    // ------------------------------------------------------------
    // release steps
    // ------------------------------------------------------------
    // ready needs two sync stages and one step edge
    sequence s_ready_seen;
        $rose(rdy) && en && !rst;
    endsequence
    sequence s_release;
        !rst [*3] ##1 rst;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    rst_latency_a: assert property (s_ready_seen |-> s_release)
        else $error("standby reset released at wrong edge");
    rst_cause_a: assert property ($rose(rst) |-> $past(rdy, 3))
        else $error("standby reset released without ready");
    rst_needs_en_a: assert property (rst |-> en)
        else $error("standby reset released before enable");
    soft_follow_a: assert property ($rose(rst) |=> soft_off_grant)
        else $error("soft-off grant late after reset release");
    soft_gated_a: assert property (soft_off_grant |-> rst)
        else $error("soft-off grant while standby reset held");
    on_order_a: assert property (power_on_grant |-> soft_off_grant)
        else $error("power-on grant before soft-off grant");
    en_stands_a: assert property (en |=> en)
        else $error("standby enable dropped");
    on_stands_a: assert property (power_on_grant |=> power_on_grant)
        else $error("power-on grant dropped");
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// tb_top.sv - both ends face to face, random and corner stimulus
// assumes: design package compiled first, 100 MHz clock
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import sbseq_pkg::*;
;
    logic       i_clk_sys;
    logic       i_reset_n = 1'b0;
    logic       m_aux = 1'b0, m_boot = 1'b0, m_rails = 1'b0, m_pon = 1'b0;
    logic       m_tx0 = 1'b1, m_tx1 = 1'b1, h_tx0 = 1'b1, h_tx1 = 1'b1;
    logic       h_aux = 1'b0, h_cfg = 1'b0, h_wake = 1'b0, h_cover = 1'b1;
    sbseq_id_t  m_id = 2'h0;
    logic       m_rx0, m_rx1, m_idrq, m_intr, m_halt;
    logic       h_rx0, h_rx1, h_pwr, h_auxen, h_rst, h_s5, h_on;
    sbseq_mst_e m_st;
    sbseq_hst_e h_st;
    int         n_fail = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         k;
    logic [7:0] r;

    sbseq_if lnk();

    sbseq_module_end u_sbseq_module_end
    (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(lnk),
        .i_aux_rails_good(m_aux), .i_ctrl_booted(m_boot),
        .i_stby_rails_good(m_rails), .i_id_result(m_id),
        .i_power_on_req(m_pon), .i_uart0_tx(m_tx0), .i_uart1_tx(m_tx1),
        .o_uart0_rx(m_rx0), .o_uart1_rx(m_rx1), .o_id_read_req(m_idrq),
        .o_intruded(m_intr), .o_halted(m_halt), .o_state(m_st)
    );

    sbseq_host_end u_sbseq_host_end
    (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(lnk),
        .i_aux_rails_good(h_aux), .i_fpga_configured(h_cfg),
        .i_wake_req(h_wake), .i_cover_closed(h_cover),
        .i_uart0_tx(h_tx0), .i_uart1_tx(h_tx1),
        .o_uart0_rx(h_rx0), .o_uart1_rx(h_rx1),
        .o_module_power_en(h_pwr), .o_aux_enable(h_auxen),
        .o_standby_reset_low(h_rst), .o_chipset_s5_en(h_s5),
        .o_host_on(h_on), .o_state(h_st)
    );

    sbseq_monitor u_mon
    (
        .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_module_standby_enable_out(lnk.module_standby_enable_out),
        .i_host_standby_ready_in(lnk.host_standby_ready_in),
        .i_module_standby_reset_out_low(lnk.module_standby_reset_out_low),
        .i_soft_off_grant(lnk.soft_off_grant),
        .i_power_on_grant(lnk.power_on_grant)
    );

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // whole run is well under a thousand cycles
    always @(posedge i_clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic exp_halt(input sbseq_id_t id);
        return (id == 2'h2) || (id == 2'h3);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // host aux and config are left to each scenario
    task automatic boot(input sbseq_id_t id, input logic rails);
        @(posedge i_clk_sys);
        i_reset_n <= 1'b0;
        {m_aux, m_boot, m_rails, m_pon, h_wake} <= 5'h00;
        m_id <= 2'h0;
        tick(16);
        i_reset_n <= 1'b1;
        m_aux <= 1'b1;
        tick(1 + $urandom % 3);
        m_boot <= 1'b1;
        m_id <= id;
        m_rails <= rails;
        tick(40);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hfaa9));
        // host fully ready so a wrong enable would run on
        h_aux <= 1'b1;
        h_cfg <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (i == 1)
                continue;
            boot(i[1:0], 1'b1);
            chk(m_halt, exp_halt(i[1:0]));
            chk(lnk.module_standby_enable_out, 1'b0);
            chk(m_idrq, i == 0);
        end
        tick(1);
        // pass, but own rails not good yet, host held off
        h_aux <= 1'b0;
        h_cfg <= 1'b0;
        boot(2'h1, 1'b0);
        chk(lnk.module_standby_enable_out, 1'b0);
        tick(1);
        m_rails <= 1'b1;
        tick(20);
        #1;
        chk(lnk.module_standby_enable_out, 1'b1);
        chk(h_pwr, 1'b1);
        chk(h_auxen, 1'b1);
        tick(1);
        h_aux <= 1'b1;
        tick(5 + $urandom % 8);
        #1;
        chk(lnk.module_standby_reset_out_low, 1'b0);
        tick(1);
        h_cfg <= 1'b1;
        #1;
        for (k = 0; k < 50 && lnk.module_standby_reset_out_low !== 1'b1; k++)
        begin
            tick(1);
            #1;
        end
        chk(lnk.host_standby_ready_in, 1'b1);
        chk(lnk.module_standby_reset_out_low, 1'b1);
        // late failing id must be ignored after the check step
        tick(1);
        m_id <= 2'h2;
        tick(1);
        #1;
        chk(lnk.soft_off_grant, 1'b1);
        tick(4);
        #1;
        chk(h_s5, 1'b1);
        chk(h_rst, 1'b1);
        tick(1);
        h_wake <= 1'b1;
        tick(20);
        #1;
        chk(h_on, 1'b0);
        chk(m_halt, 1'b0);
        tick(1);
        m_pon <= 1'b1;
        tick(20);
        #1;
        chk(lnk.power_on_grant, 1'b1);
        chk(h_on, 1'b1);
        chk(m_st, SBSEQ_M_ON);
        chk(h_st, SBSEQ_H_ON);
        // random intrusion and uart levels in both directions
        repeat (20)
        begin
            tick(1);
            r = 8'($urandom);
            h_cover <= r[0];
            m_tx0 <= r[1];
            m_tx1 <= r[2];
            h_tx0 <= r[3];
            h_tx1 <= r[4];
            tick(5);
            #1;
            chk(m_intr, !r[0]);
            chk(h_rx0, r[1]);
            chk(h_rx1, r[2]);
            chk(m_rx0, r[3]);
            chk(m_rx1, r[4]);
        end
        print_verdict();
    end
endmodule

`default_nettype wire
